// file: design/mcl_pkg.sv
// Constants, types and state layout of the meter control-line and alert block
package mcl_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned DEBOUNCE_US = 5000;
  localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int unsigned MSG_MS = 1000;
  localparam int unsigned MSG_CYC = CLK_HZ / 1000 * MSG_MS;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned FLASH_CYC = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BAUD_CYC = CLK_HZ / BAUD;
  localparam int unsigned MENU_ITEMS = 12;
  localparam int CW = 28;
  localparam int DW = 24;
  localparam int NP = 11;
  localparam logic signed [DW-1:0] DISP_MAX = 24'sh0f423f;
  localparam logic signed [DW-1:0] DISP_MIN = -24'sh01869f;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DISP = 8'h08;
  localparam logic [7:0] REG_PEAK = 8'h0c;
  localparam logic [7:0] REG_VALLEY = 8'h10;
  localparam logic [7:0] REG_CONFIG = 8'h14;
  localparam logic [7:0] REG_ENTRY = 8'h18;
  localparam logic [7:0] REG_UART = 8'h1c;
  localparam logic [7:0] REG_SP0 = 8'h20;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int CTRL_SCOPE = 0;
  localparam int CTRL_PRINT = 1;
  localparam int CTRL_ALRST = 2;
  localparam int CTRL_FMT = 3;
  localparam int CTRL_LATCH = 4;
  localparam int PIN_PEAK = 0;
  localparam int PIN_VALLEY = 1;
  localparam int PIN_RESET = 2;
  localparam int PIN_HOLD = 3;
  localparam int PIN_LOCK = 4;
  localparam int PIN_PRINT = 5;
  localparam int PIN_RX = 6;
  localparam logic [7:0] PRINT_TERM = 8'h0d;

  typedef enum logic [3:0] {
    MSG_NONE = 4'h0, MSG_HARD_RESET = 4'h1, MSG_DISP_OVF = 4'h2, MSG_OFFSET_OVF = 4'h3,
    MSG_SP_OVF = 4'h4, MSG_SAVED = 4'h5, MSG_NOT_SAVED = 4'h6, MSG_POS_POSITIVE_OVERLOAD_MSG = 4'h7,
    MSG_OPEN = 4'h8, MSG_UNDER = 4'h9, MSG_IN_OVSC = 4'ha, MSG_RD_OVSC = 4'hb,
    MSG_COUNT_STEP_OVERFLOW_MSG = 4'hc, MSG_UNIT_SHIFT_OVERFLOW_MSG = 4'hd, MSG_SERIAL = 4'he
  } mcl_msg_t;

  typedef enum logic [1:0] {
    MD_RUN = 2'b00, MD_SETUP = 2'b01, MD_MSG = 2'b10, MD_OFS = 2'b11
  } mcl_md_t;

  typedef struct packed {
    logic cyc; logic stb; logic we; logic [7:0] adr; logic [3:0] sel; logic [31:0] dat;
  } mcl_wb_req_t;

  typedef struct packed {
    logic ack; logic [31:0] dat;
  } mcl_wb_rsp_t;

  typedef struct packed {
    logic pos_positive_overload_msg; logic open_sensor; logic under_range; logic in_ovsc; logic rd_ovsc;
    logic count_step_overflow_msg; logic unit_shift_overflow_msg; logic offset_ovf; logic sp_ovf;
  } mcl_err_t;

  typedef struct packed {
    logic [NP-1:0] s1; logic [NP-1:0] s2; logic [NP-1:0] s3;
    logic [5:0] act; logic [5:0] actp; logic rxl;
    logic [CW-1:0] dbc; logic [CW-1:0] flc; logic flash;
    logic [CW-1:0] tmr; mcl_msg_t tmsg; mcl_md_t md; mcl_md_t ret_md;
    logic [3:0] item; logic pend; logic [2:0] dp; logic [2:0] prop;
    logic [DW-1:0] live; logic [DW-1:0] peak; logic [DW-1:0] valley;
    logic [DW-1:0] disp; logic [DW-1:0] entry; logic [3:0][DW-1:0] sp;
    logic [3:0] al; logic [3:0] al_oe_n; logic [7:0] ctrl; mcl_msg_t msg; logic dflash;
    logic tx; logic [CW-1:0] txc; logic [3:0] txb; logic [9:0] txsh; logic [2:0] txn;
    logic [31:0] txbuf;
    logic [CW-1:0] rxc; logic [3:0] rxb; logic [7:0] rxsh; logic [7:0] rxd; logic rxf; logic rxa;
    logic ack; logic [31:0] rdat;
  } mcl_st_t;
endpackage

// file: design/mcl_top.sv
// Control-line handling, alert messages, alarm outputs and aux serial of the panel meter
`timescale 1ns/1ps
module mcl_top #(
  parameter int unsigned DEB_CYC = mcl_pkg::DEBOUNCE_CYC,
  parameter int unsigned MSG_CYC = mcl_pkg::MSG_CYC,
  parameter int unsigned FLASH_CYC = mcl_pkg::FLASH_CYC,
  parameter int unsigned BAUD_CYC = mcl_pkg::BAUD_CYC,
  parameter int unsigned MENU_ITEMS = mcl_pkg::MENU_ITEMS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus
  input wire mcl_pkg::mcl_wb_req_t wb_i,
  output mcl_pkg::mcl_wb_rsp_t wb_o,
  // Rear control lines, active low
  input wire logic [5:0] ctl_n_i,
  // Measurement stream and error conditions
  input wire logic sample_vld_i,
  input wire logic [mcl_pkg::DW-1:0] sample_i,
  input wire mcl_pkg::mcl_err_t err_i,
  input wire logic [2:0] ofs_dp_max_i,
  // Front panel
  input wire logic menu_btn_i,
  input wire logic max_btn_i,
  input wire logic chg_i,
  input wire logic submenu_i,
  // Display
  output logic [mcl_pkg::DW-1:0] disp_value_o,
  output logic disp_flash_o,
  output mcl_pkg::mcl_msg_t msg_o,
  output mcl_pkg::mcl_md_t mode_o,
  output logic [3:0] menu_item_o,
  output logic [2:0] decimal_position_o,
  output logic [mcl_pkg::DW-1:0] entry_o,
  // Open-collector setpoint and alarm pins
  input wire logic [3:0] sp_i,
  output logic [3:0] sp_o,
  output logic [3:0] sp_oe_n_o,
  // Auxiliary serial pair
  input wire logic rx_i,
  output logic tx_o
);
  localparam logic [mcl_pkg::CW-1:0] DEB_M1 = mcl_pkg::CW'(DEB_CYC - 1);
  localparam logic [mcl_pkg::CW-1:0] MSG_T = mcl_pkg::CW'(MSG_CYC);
  localparam logic [mcl_pkg::CW-1:0] FLASH_M1 = mcl_pkg::CW'(FLASH_CYC - 1);
  localparam logic [mcl_pkg::CW-1:0] BAUD_M1 = mcl_pkg::CW'(BAUD_CYC - 1);
  localparam logic [mcl_pkg::CW-1:0] HALF_M1 = mcl_pkg::CW'(BAUD_CYC / 2 - 1);
  localparam logic [3:0] ITEM_LAST = 4'(MENU_ITEMS - 1);

  mcl_pkg::mcl_st_t q;
  mcl_pkg::mcl_st_t d;
  logic [3:0] raw;
  logic [5:0] ev;
  logic busy;
  logic ovf;
  logic lock;
  logic dtick;
  logic btick;
  logic menu_fire;
  logic [31:0] wv;

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Setpoint compare, one per output
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cmp
      assign raw[gi] = $signed(q.live) >= $signed(q.sp[gi]);
    end
  endgenerate

  assign ev = q.act & ~q.actp;
  assign busy = (q.txn != 3'h0) || (q.txb != 4'h0) || q.rxa;
  assign ovf = ($signed(q.live) > $signed(mcl_pkg::DISP_MAX)) || ($signed(q.live) < $signed(mcl_pkg::DISP_MIN));
  assign lock = q.act[mcl_pkg::PIN_LOCK];
  assign dtick = (q.dbc == DEB_M1);
  assign menu_fire = menu_btn_i;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    wv = 32'h0;
    btick = 1'b0;
    // Three-stage sampling of every pin
    d.s1 = {sp_i, rx_i, ctl_n_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.actp = q.act;
    // Slow sampling rejects contact bounce without per-line counters
    d.dbc = dtick ? '0 : q.dbc + 1'b1;
    if (dtick) begin
      for (int i = 0; i < 6; i++) begin
        if (q.s2[i] == q.s3[i]) begin
          d.act[i] = ~q.s3[i];
        end
      end
    end
    if (q.s2[mcl_pkg::PIN_RX] == q.s3[mcl_pkg::PIN_RX]) begin
      d.rxl = q.s3[mcl_pkg::PIN_RX];
    end
    d.flc = (q.flc == FLASH_M1) ? '0 : q.flc + 1'b1;
    if (q.flc == FLASH_M1) begin
      d.flash = ~q.flash;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampling, peak and valley keep running regardless of hold
    if (sample_vld_i) begin
      d.live = sample_i;
      if ($signed(sample_i) > $signed(q.peak)) begin
        d.peak = sample_i;
      end
      if ($signed(sample_i) < $signed(q.valley)) begin
        d.valley = sample_i;
      end
    end
    if (!q.act[mcl_pkg::PIN_HOLD]) begin
      if (ovf) begin
        d.disp = mcl_pkg::DISP_MAX;
      end else if (q.act[mcl_pkg::PIN_PEAK]) begin
        d.disp = q.peak;
      end else if (q.act[mcl_pkg::PIN_VALLEY]) begin
        d.disp = q.valley;
      end else begin
        d.disp = q.live;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarms: a fresh trip wins over a latch clear in the same cycle
    for (int i = 0; i < 4; i++) begin
      d.al[i] = raw[i] | (q.ctrl[mcl_pkg::CTRL_LATCH + i] & q.al[i]);
    end
    if (ev[mcl_pkg::PIN_PRINT] && q.ctrl[mcl_pkg::CTRL_ALRST]) begin
      d.al = raw;
    end

    ////////////////////////////////////////////////////////////////////////
    // Timed messages and menu
    if (q.tmr != '0) begin
      d.tmr = q.tmr - 1'b1;
      if (q.tmr == 28'h1) begin
        d.tmsg = mcl_pkg::MSG_NONE;
        if (q.md == mcl_pkg::MD_MSG) begin
          d.md = q.ret_md;
        end
      end
    end
    unique case (q.md)
      mcl_pkg::MD_RUN: begin
        if (err_i.sp_ovf) begin
          d.md = mcl_pkg::MD_MSG;
          d.ret_md = mcl_pkg::MD_RUN;
          d.tmsg = mcl_pkg::MSG_SP_OVF;
          d.tmr = MSG_T;
        end else if (menu_fire && err_i.offset_ovf) begin
          d.md = mcl_pkg::MD_OFS;
          d.prop = ofs_dp_max_i;
        end else if (menu_fire && !lock) begin
          if (busy) begin
            d.md = mcl_pkg::MD_MSG;
            d.ret_md = mcl_pkg::MD_RUN;
            d.tmsg = mcl_pkg::MSG_SERIAL;
            d.tmr = MSG_T;
          end else begin
            d.md = mcl_pkg::MD_SETUP;
            d.item = 4'h0;
            d.pend = 1'b0;
          end
        end
      end
      mcl_pkg::MD_SETUP: begin
        if (chg_i) begin
          if (busy) begin
            d.md = mcl_pkg::MD_MSG;
            d.ret_md = mcl_pkg::MD_SETUP;
            d.tmsg = mcl_pkg::MSG_SERIAL;
            d.tmr = MSG_T;
          end else begin
            d.pend = 1'b1;
          end
        end else if (menu_fire && !submenu_i) begin
          d.item = (q.item == ITEM_LAST) ? 4'h0 : q.item + 1'b1;
          d.pend = 1'b0;
          if (q.pend) begin
            d.md = mcl_pkg::MD_MSG;
            d.ret_md = (q.item == ITEM_LAST) ? mcl_pkg::MD_RUN : mcl_pkg::MD_SETUP;
            d.tmsg = lock ? mcl_pkg::MSG_NOT_SAVED : mcl_pkg::MSG_SAVED;
            d.tmr = MSG_T;
          end else if (q.item == ITEM_LAST) begin
            d.md = mcl_pkg::MD_RUN;
          end
        end
      end
      mcl_pkg::MD_MSG: begin
      end
      mcl_pkg::MD_OFS: begin
        if (menu_fire) begin
          if (!lock) begin
            d.dp = q.prop;
          end
          d.md = mcl_pkg::MD_RUN;
        end
      end
    endcase

    if (max_btn_i && q.msg == mcl_pkg::MSG_DISP_OVF) begin
      d.entry = '0;
    end

    // Hard reset or peak/valley clear from the reset line
    if (ev[mcl_pkg::PIN_RESET]) begin
      d.peak = q.live;
      d.valley = q.live;
      if (!q.ctrl[mcl_pkg::CTRL_SCOPE]) begin
        d.ctrl = mcl_pkg::CTRL_RST;
        d.sp = '0;
        d.dp = 3'h0;
        d.al = '0;
        d.md = mcl_pkg::MD_RUN;
        d.tmsg = mcl_pkg::MSG_HARD_RESET;
        d.tmr = MSG_T;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Single message, fixed priority
    if (q.tmsg != mcl_pkg::MSG_NONE) begin
      d.msg = q.tmsg;
    end else if (err_i.pos_positive_overload_msg) begin
      d.msg = mcl_pkg::MSG_POS_POSITIVE_OVERLOAD_MSG;
    end else if (err_i.open_sensor) begin
      d.msg = mcl_pkg::MSG_OPEN;
    end else if (err_i.under_range) begin
      d.msg = mcl_pkg::MSG_UNDER;
    end else if (err_i.in_ovsc) begin
      d.msg = mcl_pkg::MSG_IN_OVSC;
    end else if (err_i.rd_ovsc) begin
      d.msg = mcl_pkg::MSG_RD_OVSC;
    end else if (err_i.count_step_overflow_msg) begin
      d.msg = mcl_pkg::MSG_COUNT_STEP_OVERFLOW_MSG;
    end else if (err_i.unit_shift_overflow_msg) begin
      d.msg = mcl_pkg::MSG_UNIT_SHIFT_OVERFLOW_MSG;
    end else if (err_i.offset_ovf) begin
      d.msg = mcl_pkg::MSG_OFFSET_OVF;
    end else if (ovf) begin
      d.msg = mcl_pkg::MSG_DISP_OVF;
    end else begin
      d.msg = mcl_pkg::MSG_NONE;
    end
    d.dflash = q.flash & ((d.msg != mcl_pkg::MSG_NONE) || q.act[mcl_pkg::PIN_PEAK] || q.act[mcl_pkg::PIN_VALLEY]);

    ////////////////////////////////////////////////////////////////////////
    // Serial transmit: start bit on load, then data, stop, one idle clock
    if (q.txb != 4'h0) begin
      btick = (q.txc == BAUD_M1);
      d.txc = btick ? '0 : q.txc + 1'b1;
      if (btick) begin
        d.tx = q.txsh[0];
        d.txsh = {1'b1, q.txsh[9:1]};
        d.txb = q.txb - 1'b1;
      end
    end else if (q.txn != 3'h0) begin
      d.tx = 1'b0;
      d.txsh = {2'b11, q.txbuf[31:24]};
      d.txbuf = {q.txbuf[23:0], 8'h00};
      d.txn = q.txn - 1'b1;
      d.txb = 4'ha;
      d.txc = '0;
    end
    if (ev[mcl_pkg::PIN_PRINT] && q.ctrl[mcl_pkg::CTRL_PRINT] && !busy) begin
      d.txbuf = {q.live, mcl_pkg::PRINT_TERM};
      d.txn = q.ctrl[mcl_pkg::CTRL_FMT] ? 3'h4 : 3'h3;
    end

    // Serial receive, start bit checked at mid-bit
    if (!q.rxa) begin
      if (!q.rxl) begin
        d.rxa = 1'b1;
        d.rxc = '0;
        d.rxb = 4'h0;
      end
    end else if (q.rxc == ((q.rxb == 4'h0) ? HALF_M1 : BAUD_M1)) begin
      d.rxc = '0;
      if (q.rxb == 4'h0) begin
        d.rxa = ~q.rxl;
        d.rxb = 4'h1;
      end else if (q.rxb <= 4'h8) begin
        d.rxsh = {q.rxl, q.rxsh[7:1]};
        d.rxb = q.rxb + 1'b1;
      end else begin
        d.rxa = 1'b0;
      end
    end else begin
      d.rxc = q.rxc + 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone classic slave, one wait state
    d.ack = wb_i.cyc && wb_i.stb && !q.ack;
    d.rdat = 32'h0;
    if (d.ack) begin
      unique case (wb_i.adr)
        mcl_pkg::REG_CTRL: d.rdat = {24'h0, q.ctrl};
        mcl_pkg::REG_STATUS: d.rdat = {4'h0, q.msg, 2'h0, q.md, q.al, q.s3[10:7], 3'h0, busy, 2'h0, q.act};
        mcl_pkg::REG_DISP: d.rdat = {8'h0, q.disp};
        mcl_pkg::REG_PEAK: d.rdat = {8'h0, q.peak};
        mcl_pkg::REG_VALLEY: d.rdat = {8'h0, q.valley};
        mcl_pkg::REG_CONFIG: d.rdat = {29'h0, q.dp};
        mcl_pkg::REG_ENTRY: d.rdat = {8'h0, q.entry};
        mcl_pkg::REG_UART: d.rdat = {23'h0, q.rxf, q.rxd};
        8'h20, 8'h24, 8'h28, 8'h2c: d.rdat = {8'h0, q.sp[wb_i.adr[3:2]]};
        default: d.rdat = 32'h0;
      endcase
      if (!wb_i.we && wb_i.adr == mcl_pkg::REG_UART) begin
        d.rxf = 1'b0;
      end
      if (wb_i.we && !lock) begin
        unique case (wb_i.adr)
          mcl_pkg::REG_CTRL: begin
            wv = wmerge({24'h0, q.ctrl}, wb_i.dat, wb_i.sel);
            d.ctrl = wv[7:0];
          end
          mcl_pkg::REG_CONFIG: begin
            wv = wmerge({29'h0, q.dp}, wb_i.dat, wb_i.sel);
            d.dp = wv[2:0];
          end
          mcl_pkg::REG_ENTRY: begin
            wv = wmerge({8'h0, q.entry}, wb_i.dat, wb_i.sel);
            d.entry = wv[23:0];
          end
          8'h20, 8'h24, 8'h28, 8'h2c: begin
            wv = wmerge({8'h0, q.sp[wb_i.adr[3:2]]}, wb_i.dat, wb_i.sel);
            d.sp[wb_i.adr[3:2]] = wv[23:0];
          end
          default: begin
          end
        endcase
      end
      if (wb_i.we && wb_i.adr == mcl_pkg::REG_UART && wb_i.sel[0] && !busy) begin
        d.txbuf = {wb_i.dat[7:0], 24'h0};
        d.txn = 3'h1;
      end
    end
    // Received byte sets the flag after any read clear
    if (q.rxa && q.rxb == 4'h9 && q.rxc == BAUD_M1 && q.rxl) begin
      d.rxd = q.rxsh;
      d.rxf = 1'b1;
    end
    d.al_oe_n = ~d.al;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.s1 <= '1;
      q.s2 <= '1;
      q.s3 <= '1;
      q.rxl <= 1'b1;
      q.tx <= 1'b1;
      q.al_oe_n <= 4'hf;
      q.ctrl <= mcl_pkg::CTRL_RST;
      q.md <= mcl_pkg::MD_RUN;
      q.ret_md <= mcl_pkg::MD_RUN;
      q.tmsg <= mcl_pkg::MSG_NONE;
      q.msg <= mcl_pkg::MSG_NONE;
    end else begin
      q <= d;
    end
  end

  assign wb_o = '{ack: q.ack, dat: q.rdat};
  assign disp_value_o = q.disp;
  assign disp_flash_o = q.dflash;
  assign msg_o = q.msg;
  assign mode_o = q.md;
  assign menu_item_o = q.item;
  assign decimal_position_o = q.dp;
  assign entry_o = q.entry;
  assign sp_o = 4'h0;
  assign sp_oe_n_o = q.al_oe_n;
  assign tx_o = q.tx;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_print_req;
    ev[mcl_pkg::PIN_PRINT] && q.ctrl[mcl_pkg::CTRL_PRINT] && !busy;
  endsequence
  sequence s_tx_start;
    (q.txn != 3'h0) ##1 (q.tx == 1'b0);
  endsequence

  AST_PEAK_SHOW: assert property (q.act[0] && !q.act[3] && !ovf |=> q.disp == $past(q.peak))
    else $error("peak value not shown");
  AST_VALLEY_SHOW: assert property (q.act[1] && !q.act[0] && !q.act[3] && !ovf |=> q.disp == $past(q.valley))
    else $error("valley value not shown");
  AST_PV_CLEAR: assert property (ev[2] && q.ctrl[0] && !sample_vld_i |=> q.peak == q.valley && q.md == $past(q.md))
    else $error("peak/valley clear wrong");
  AST_HOLD: assert property (q.act[3] && $past(q.act[3]) |-> $stable(q.disp))
    else $error("display moved under hold");
  AST_LOCK: assert property (q.md == mcl_pkg::MD_RUN && lock && menu_btn_i && !err_i.sp_ovf && !err_i.offset_ovf
    && !ev[2] |=> q.md == mcl_pkg::MD_RUN)
    else $error("setup entered under lockout");
  AST_PRINT: assert property (s_print_req |=> s_tx_start)
    else $error("printout did not start");
  AST_ALRST: assert property (ev[5] && q.ctrl[2] && !ev[2] |=> (q.al & ~$past(raw)) == 4'h0)
    else $error("latched alarm survived reset");
  AST_OC: assert property (q.al_oe_n == ~q.al && sp_o == 4'h0)
    else $error("open-collector drive mismatch");
  AST_OVF: assert property (ovf && !q.act[3] |=> q.disp == mcl_pkg::DISP_MAX && q.msg != mcl_pkg::MSG_NONE)
    else $error("overflow not shown");
  AST_PRIO: assert property (err_i.in_ovsc && err_i.rd_ovsc |=> q.msg != mcl_pkg::MSG_RD_OVSC)
    else $error("reading overscale outranked input overscale");
  AST_SP_RET: assert property (q.md == mcl_pkg::MD_MSG |-> q.tmr <= MSG_T && q.tmr != '0)
    else $error("message mode without bounded timer");
endmodule

// file: dv/mcl_panel_model.sv
// Rear switch panel and setpoint relay model for the meter control block
`timescale 1ns/1ps
module mcl_panel_model (
  // Switch closures asked for by the bench
  input wire logic [5:0] close_i,
  // Open-collector drive from the meter
  input wire logic [3:0] sp_o_i,
  input wire logic [3:0] sp_oe_n_i,
  // Lines seen by the meter
  output logic [5:0] ctl_n_o,
  output logic [3:0] sp_pin_o,
  output logic rx_o
);
  // Open switch leaves the pulled-up line high
  assign ctl_n_o = ~close_i;
  // Relay pull-up wins while the transistor is off
  assign sp_pin_o = sp_oe_n_i | sp_o_i;
  assign rx_o = 1'b1;
endmodule

// file: dv/tb.sv
// Self-checking bench for the meter control-line and alert block
`timescale 1ns/1ps
module tb;
  logic clk_i, rst_i, sample_vld_i, rx_i, tx_o, disp_flash_o;
  logic [5:0] close, ctl_n;
  logic [3:0] sp_pin, sp_o, sp_oe_n_o, menu_item_o;
  logic [2:0] decimal_position_o, ofs_dp_max;
  logic menu_btn, max_btn, chg, submenu;
  logic [23:0] sample_i, disp_value_o, entry_o;
  logic [31:0] q;
  mcl_pkg::mcl_wb_req_t req;
  mcl_pkg::mcl_wb_rsp_t rsp;
  mcl_pkg::mcl_err_t err;
  mcl_pkg::mcl_msg_t msg_o;
  mcl_pkg::mcl_md_t mode_o;
  int error_cnt, comparisons;

  mcl_top #(.DEB_CYC(4), .MSG_CYC(20), .FLASH_CYC(4), .BAUD_CYC(8), .MENU_ITEMS(12)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .ctl_n_i(ctl_n),
    .sample_vld_i(sample_vld_i), .sample_i(sample_i), .err_i(err), .ofs_dp_max_i(ofs_dp_max),
    .menu_btn_i(menu_btn), .max_btn_i(max_btn), .chg_i(chg), .submenu_i(submenu),
    .disp_value_o(disp_value_o), .disp_flash_o(disp_flash_o), .msg_o(msg_o), .mode_o(mode_o),
    .menu_item_o(menu_item_o), .decimal_position_o(decimal_position_o), .entry_o(entry_o),
    .sp_i(sp_pin), .sp_o(sp_o), .sp_oe_n_o(sp_oe_n_o), .rx_i(rx_i), .tx_o(tx_o));

  mcl_panel_model i_panel (.close_i(close), .sp_o_i(sp_o), .sp_oe_n_i(sp_oe_n_o),
    .ctl_n_o(ctl_n), .sp_pin_o(sp_pin), .rx_o(rx_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Classic cycle: hold everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    @(posedge clk_i);
    while (rsp.ack !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n++;
    end
    q = rsp.dat;
    if (n == 50) chk(32'h0, 32'h1);
    req <= '0;
    @(posedge clk_i);
  endtask

  task automatic smp(input logic [23:0] v);
    sample_i <= v;
    sample_vld_i <= 1'b1;
    @(posedge clk_i);
    sample_vld_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  // One-cycle front panel pulse: 0 menu, 1 change, 2 max
  task automatic press(input int k);
    menu_btn <= (k == 0);
    chg <= (k == 1);
    max_btn <= (k == 2);
    @(posedge clk_i);
    {menu_btn, chg, max_btn} <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask

  // Sync stages, one debounce tick, event and output register
  task automatic sw(input int i, input logic v);
    close[i] <= v;
    repeat (12) @(posedge clk_i);
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_peak_valley;
    logic hi, lo;
    wb(1'b1, mcl_pkg::REG_CTRL, 32'h1);
    smp(24'd100);
    sw(mcl_pkg::PIN_RESET, 1'b1);
    sw(mcl_pkg::PIN_RESET, 1'b0);
    chk(msg_o, mcl_pkg::MSG_NONE);
    wb(1'b0, mcl_pkg::REG_PEAK, 32'h0);
    chk(q, 32'd100);
    smp(24'd500);
    smp(24'd200);
    sw(mcl_pkg::PIN_PEAK, 1'b1);
    chk(disp_value_o, 24'd500);
    hi = 1'b0;
    lo = 1'b0;
    repeat (10) begin
      @(posedge clk_i);
      hi |= (disp_flash_o === 1'b1);
      lo |= (disp_flash_o === 1'b0);
    end
    chk({hi, lo}, 2'b11);
    sw(mcl_pkg::PIN_PEAK, 1'b0);
    sw(mcl_pkg::PIN_VALLEY, 1'b1);
    chk(disp_value_o, 24'd100);
    sw(mcl_pkg::PIN_VALLEY, 1'b0);
    chk(disp_value_o, 24'd200);
  endtask

  task automatic t_hold;
    sw(mcl_pkg::PIN_HOLD, 1'b1);
    smp(24'd50);
    chk(disp_value_o, 24'd200);
    wb(1'b0, mcl_pkg::REG_VALLEY, 32'h0);
    chk(q, 32'd50);
    sw(mcl_pkg::PIN_HOLD, 1'b0);
    chk(disp_value_o, 24'd50);
  endtask

  task automatic t_alarm_lock;
    for (int i = 0; i < 4; i++) wb(1'b1, mcl_pkg::REG_SP0 + 8'(4 * i), (i == 0) ? 32'd300 : 32'd1000);
    smp(24'd400);
    chk(sp_oe_n_o, 4'he);
    // Pin readback passes three sync stages
    repeat (3) @(posedge clk_i);
    wb(1'b0, mcl_pkg::REG_STATUS, 32'h0);
    chk(q[15:12], 4'he);
    chk(q[19:16], 4'h1);
    sw(mcl_pkg::PIN_LOCK, 1'b1);
    wb(1'b1, mcl_pkg::REG_SP0 + 8'h04, 32'h0);
    wb(1'b0, mcl_pkg::REG_SP0 + 8'h04, 32'h0);
    chk(q, 32'd1000);
    press(0);
    chk(mode_o, mcl_pkg::MD_RUN);
    sw(mcl_pkg::PIN_LOCK, 1'b0);
  endtask

  task automatic t_menu_ovf;
    press(0);
    chk(mode_o, mcl_pkg::MD_SETUP);
    submenu <= 1'b1;
    press(0);
    chk(menu_item_o, 4'h0);
    submenu <= 1'b0;
    press(1);
    press(0);
    chk(msg_o, mcl_pkg::MSG_SAVED);
    chk(menu_item_o, 4'h1);
    repeat (24) @(posedge clk_i);
    chk(mode_o, mcl_pkg::MD_SETUP);
    repeat (11) press(0);
    chk(mode_o, mcl_pkg::MD_RUN);
    ofs_dp_max <= 3'h2;
    err.offset_ovf <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(msg_o, mcl_pkg::MSG_OFFSET_OVF);
    press(0);
    chk(mode_o, mcl_pkg::MD_OFS);
    press(0);
    chk(decimal_position_o, 3'h2);
    err <= '0;
    wb(1'b1, mcl_pkg::REG_ENTRY, 32'h5);
    chk(entry_o, 24'h5);
    smp(24'h0f4240);
    chk(disp_value_o, mcl_pkg::DISP_MAX);
    chk(msg_o, mcl_pkg::MSG_DISP_OVF);
    press(2);
    chk(entry_o, 24'h0);
    smp(24'd400);
  endtask

  task automatic t_priority;
    err <= '{in_ovsc: 1'b1, rd_ovsc: 1'b1, default: 1'b0};
    repeat (3) @(posedge clk_i);
    chk(msg_o, mcl_pkg::MSG_IN_OVSC);
    err.pos_positive_overload_msg <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(msg_o, mcl_pkg::MSG_POS_POSITIVE_OVERLOAD_MSG);
    err <= '0;
    repeat (3) @(posedge clk_i);
  endtask

  // First printed byte is the top byte of the reading, LSB first
  task automatic t_print;
    logic [7:0] b;
    int n;
    n = 0;
    smp(24'h0a0b0c);
    wb(1'b1, mcl_pkg::REG_CTRL, 32'h2);
    close[mcl_pkg::PIN_PRINT] <= 1'b1;
    while (tx_o !== 1'b0 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    repeat (12) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      b[i] = tx_o;
      repeat (8) @(posedge clk_i);
    end
    chk(b, 8'h0a);
    chk(tx_o, 1'b1);
    sw(mcl_pkg::PIN_PRINT, 1'b0);
  endtask

  task automatic t_hard_reset;
    wb(1'b1, mcl_pkg::REG_CTRL, 32'h0);
    sw(mcl_pkg::PIN_RESET, 1'b1);
    chk(msg_o, mcl_pkg::MSG_HARD_RESET);
    wb(1'b0, mcl_pkg::REG_SP0, 32'h0);
    chk(q, 32'h0);
    sw(mcl_pkg::PIN_RESET, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    error_cnt = 0;
    comparisons = 0;
    rst_i = 1'b1;
    req = '0;
    err = '0;
    close = '0;
    sample_vld_i = 1'b0;
    sample_i = '0;
    {menu_btn, max_btn, chg, submenu} = 4'h0;
    ofs_dp_max = 3'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk(sp_oe_n_o, 4'hf);
    chk(tx_o, 1'b1);
    wb(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    t_peak_valley();
    t_hold();
    t_alarm_lock();
    t_menu_ovf();
    t_priority();
    t_print();
    t_hard_reset();
    report_and_stop();
  end

  // Whole run needs well under 5000 cycles
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
endmodule
